// ### tb_watchdog_reset_timer.sv
// Testbench for the watchdog reset timer: reads, service, timeout pulse, disables.
// Assumes wdrt_top driven straight from here; stop, fetch and internal reset come as pulses.
`timescale 1ns/1ps
module tb_watchdog_reset_timer;
    localparam logic [7:0] VEC = 8'h5A; // Arbitrary vector low byte
    logic clk_i = 0, sys_rst_i = 1, wr_i = 0, rd_i = 0, rd_q = 0, fclr = 0;
    logic rate = 0, dis = 0, mon = 0, hv_irq = 0, brk = 0, hv_rst = 0;
    logic sten = 0, stex = 0, vf = 0, irst = 0;
    logic [15:0] addr_i = 16'h0000;
    logic [7:0] wdata_i = 8'h00, rdata_o;
    logic reset_pin_n_o, reset_pin_oe_o, watchdog_flag_o, irq_o;
    logic [7:0] exp_q[$];
    logic [5:0] cfg [5] = '{6'b01_0000, 6'b00_1100, 6'b00_1001, 6'b00_0011, 6'b10_0000};
    int n_fail = 0, checks_done = 0, n_pulse = 0, cyc = 0;
    wdrt_top #(.POR_DELAY(16), .VECTOR_LO(VEC)) i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .watchdog_disable_bit_i(dis), .watchdog_rate_select_i(rate), .stop_enable_i(sten),
        .stop_exec_i(stex), .vector_fetch_i(vf), .internal_reset_i(irst),
        .monitor_mode_i(mon), .break_state_i(brk), .hv_on_reset_pin_i(hv_rst),
        .hv_on_irq_pin_i(hv_irq), .flag_clear_i(fclr), .reset_pin_n_o(reset_pin_n_o),
        .reset_pin_oe_o(reset_pin_oe_o), .watchdog_flag_o(watchdog_flag_o), .irq_o(irq_o));
    // Compare helper
    task automatic check(input logic ok, input string msg);
        checks_done++;
        if (!ok) begin
            n_fail++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask : check
    // Verdict and end of run
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : print_verdict
    // One bus cycle; reads note their expected data
    task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] e);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= 8'($urandom);
        if (wr) wr_i <= 1'b1;
        else begin
            rd_i <= 1'b1;
            exp_q.push_back(e);
        end
        @(posedge clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
    endtask : bus
    // Clock
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    // Output watcher, pulse counter and hang limit
    always @(posedge clk_i) begin
        rd_q <= rd_i;
        cyc <= cyc + 1;
        if (rd_q) check(exp_q.size() > 0 && rdata_o === exp_q.pop_front(), "read data");
        if (!sys_rst_i && irq_o !== 1'b0) check(1'b0, "interrupt raised");
        if (cyc == 95000) begin
            n_fail++;
            print_verdict();
        end
    end
    always @(negedge reset_pin_n_o) n_pulse++;
    // Main sequence
    initial begin
        int k, t0, n;
        k = $urandom(32'h6af8fb53);
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        check(reset_pin_n_o === 1'b1 && reset_pin_oe_o === 1'b0 && watchdog_flag_o === 1'b0,
            "reset values");
        bus(1'b1, 16'hFFFF, 8'h00);
        bus(1'b0, 16'hFFFF, VEC);
        bus(1'b0, 16'hFFFE, 8'h00);
        for (int i = 0; i < 6; i++) bus(1'b0, {1'b0, 15'($urandom)}, 8'h00);
        repeat (3) @(posedge clk_i);
        $display("test reads done");
        for (int i = 0; i < 3; i++) begin
            repeat (4000) @(posedge clk_i);
            bus(1'b1, 16'hFFFF, 8'h00);
        end
        check(n_pulse === 0, "reset despite service");
        t0 = cyc;
        bus(1'b1, 16'hFFFE, 8'h00);
        stex <= 1'b1;
        @(posedge clk_i);
        stex <= 1'b0;
        n = 0;
        while (reset_pin_n_o !== 1'b0 && n < 9000) begin
            @(posedge clk_i);
            n++;
        end
        check(cyc - t0 >= 8176 && cyc - t0 <= 8196, "timeout length");
        check(reset_pin_oe_o === 1'b1, "pin not driven");
        n = 0;
        while (reset_pin_n_o === 1'b0 && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        check(n === 32 && watchdog_flag_o === 1'b1, "pulse or flag");
        @(posedge clk_i);
        fclr <= 1'b1;
        @(posedge clk_i);
        fclr <= 1'b0;
        repeat (2) @(posedge clk_i);
        check(watchdog_flag_o === 1'b0 && reset_pin_oe_o === 1'b0, "flag clear");
        $display("test timeout done");
        for (int j = 0; j < 3; j++) begin
            bus(1'b1, 16'hFFFF, 8'h00);
            k = n_pulse;
            for (int i = 0; i < 85; i++) begin
                @(posedge clk_i);
                sten <= (j == 0);
                stex <= (j == 0 && i == 0);
                vf <= (j == 1);
                irst <= (j == 2);
                @(posedge clk_i);
                stex <= 1'b0;
                vf <= 1'b0;
                irst <= 1'b0;
                repeat (98) @(posedge clk_i);
            end
            check(n_pulse === k, "reset in stop or clear test");
        end
        bus(1'b1, 16'hFFFF, 8'h00);
        $display("test stop and clears done");
        for (int j = 0; j < 5; j++) begin
            @(posedge clk_i);
            {rate, dis, mon, hv_irq, brk, hv_rst} <= cfg[j];
            bus(1'b1, 16'hFFFF, 8'h00);
            k = n_pulse;
            repeat (8500) @(posedge clk_i);
            check(n_pulse === k, "reset while held off");
            {rate, dis, mon, hv_irq, brk, hv_rst} <= 6'b00_0000;
            bus(1'b1, 16'hFFFF, 8'h00);
        end
        $display("test disables done");
        print_verdict();
    end
endmodule : tb_watchdog_reset_timer

// ### wdrt_pkg.sv
// Constants for the watchdog reset timer.
// Assumes a plain register port on the processor bus and one oscillator clock.
package wdrt_pkg;
    localparam logic [15:0] WDRT_SERVICE_ADDR = 16'hFFFF;
    localparam logic [15:0] WDRT_VECTOR_HI_ADDR = 16'hFFFE;
    localparam int WDRT_PRESC_W = 12;
    localparam int WDRT_CNT_W = 6;
    localparam int WDRT_SVC_CLR_LSB = 4;
    localparam int WDRT_RST_PULSE = 32;
    localparam int WDRT_POR_DELAY = 4096;
    localparam int WDRT_SHORT_TIMEOUT = 8176; // Shortest short-rate timeout, 2^13 - 2^4
    localparam int WDRT_LONG_TIMEOUT = 262128; // Shortest long-rate timeout, 2^18 - 2^4
    localparam logic [7:0] WDRT_VECTOR_LO_DEF = 8'h00;
endpackage : wdrt_pkg

// ### wdrt_top.sv
// Watchdog reset timer: prescaler, counter, reset pulse and service port.
// Assumes strobes on clk_i and pins that arrive asynchronously.
`timescale 1ns/1ps
module wdrt_top #(
    parameter int POR_DELAY = wdrt_pkg::WDRT_POR_DELAY,
    parameter logic [7:0] VECTOR_LO = wdrt_pkg::WDRT_VECTOR_LO_DEF
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Register port
    input wire logic [15:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // Configuration and core status
    input wire logic watchdog_disable_bit_i,
    input wire logic watchdog_rate_select_i,
    input wire logic stop_enable_i,
    input wire logic stop_exec_i,
    input wire logic vector_fetch_i,
    input wire logic internal_reset_i,
    input wire logic monitor_mode_i,
    input wire logic break_state_i,
    // Pins
    input wire logic hv_on_reset_pin_i,
    input wire logic hv_on_irq_pin_i,
    input wire logic flag_clear_i,
    output logic reset_pin_n_o,
    output logic reset_pin_oe_o,
    output logic watchdog_flag_o,
    output logic irq_o
);
    logic [1:0] hv_rst_sync;
    logic [1:0] hv_irq_sync;
    logic [11:0] presc;
    logic [5:0] cnt;
    logic [5:0] pulse_cnt;
    logic [12:0] por_cnt;
    logic por_done;
    logic stopped;
    logic [5:0] next_cnt;
    logic [11:0] next_presc;

    // Pin synchronisers
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            hv_rst_sync <= 2'h0;
            hv_irq_sync <= 2'h0;
        end else begin
            hv_rst_sync <= {hv_rst_sync[0], hv_on_reset_pin_i};
            hv_irq_sync <= {hv_irq_sync[0], hv_on_irq_pin_i};
        end
    end

    // Decode and enables
    wire svc_wr = wr_i && (addr_i == wdrt_pkg::WDRT_SERVICE_ADDR);
    wire hv_rst = hv_rst_sync[1];
    wire hv_irq = hv_irq_sync[1];
    wire mon_off = monitor_mode_i && (hv_rst || hv_irq);
    wire brk_off = break_state_i && hv_rst;
    wire wd_off = watchdog_disable_bit_i || mon_off || brk_off;
    wire stop_go = stop_exec_i && stop_enable_i;
    wire pulsing = (pulse_cnt != 6'h00);
    wire run = !wd_off && !stopped && !pulsing;
    wire presc_full = (presc == 12'hFFF);
    // Long timeout uses full prescaler; short tap is bit 6 carry
    wire tick = watchdog_rate_select_i ? presc_full : (presc[6:0] == 7'h7F);
    wire ovf = run && tick && (cnt == 6'h3F);
    wire por_hit = !por_done && (por_cnt == 13'(POR_DELAY - 1));

    // Next counter and prescaler
    always_comb begin
        next_presc = run ? presc + 12'h001 : presc;
        next_cnt = (run && tick) ? cnt + 6'h01 : cnt;
        if (svc_wr) begin
            next_presc = {8'h00, presc[3:0]};
            next_cnt = 6'h00;
        end
        if (stop_go || vector_fetch_i || por_hit) begin
            next_presc = 12'h000;
        end
        if (internal_reset_i || ovf) begin
            next_presc = 12'h000;
            next_cnt = 6'h00;
        end
    end

    // Counter state
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            presc <= 12'h000;
            cnt <= 6'h00;
        end else begin
            presc <= next_presc;
            cnt <= next_cnt;
        end
    end

    // Stop state, left on any bus or reset activity
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            stopped <= 1'b0;
        end else if (stop_go) begin
            stopped <= 1'b1;
        end else if (internal_reset_i || wr_i || rd_i || vector_fetch_i) begin
            stopped <= 1'b0;
        end
    end

    // Power-on delay counter
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            por_cnt <= 13'h0000;
            por_done <= 1'b0;
        end else if (!por_done) begin
            por_cnt <= por_cnt + 13'h0001;
            por_done <= por_hit;
        end
    end

    // Reset pulse and status flag
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pulse_cnt <= 6'h00;
            watchdog_flag_o <= 1'b0;
            reset_pin_n_o <= 1'b1;
            reset_pin_oe_o <= 1'b0;
        end else begin
            if (ovf) begin
                pulse_cnt <= 6'(wdrt_pkg::WDRT_RST_PULSE);
            end else if (pulsing) begin
                pulse_cnt <= pulse_cnt - 6'h01;
            end
            reset_pin_n_o <= !(ovf || pulse_cnt > 6'h01);
            reset_pin_oe_o <= ovf || pulse_cnt > 6'h01;
            if (ovf) begin
                watchdog_flag_o <= 1'b1;
            end else if (flag_clear_i) begin
                watchdog_flag_o <= 1'b0;
            end
        end
    end

    // Read port: service location returns vector low byte
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_o <= 8'h00;
            irq_o <= 1'b0;
        end else begin
            rdata_o <= (rd_i && addr_i == wdrt_pkg::WDRT_SERVICE_ADDR) ? VECTOR_LO : 8'h00;
            irq_o <= 1'b0;
        end
    end

    // Checks: the helpers below watch the design only and never feed it.
    // Bounds are derived from the tap positions, so a slip in the prescaler
    // or counter width shows up as an early timeout here.

    // Length of the running low phase on the reset pin, for the pulse checks
    logic [6:0] low_len;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            low_len <= 7'h00;
        end else if (!reset_pin_n_o) begin
            low_len <= low_len + 7'h01;
        end else begin
            low_len <= 7'h00;
        end
    end

    // Cycles since the counter was last cleared, saturating; long_run says that
    // the long rate was selected at that clear and has stayed selected since
    logic [18:0] clr_age;
    logic long_run;
    wire cnt_clear = svc_wr || internal_reset_i || ovf;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            clr_age <= 19'h0_0000;
            long_run <= 1'b0;
        end else if (cnt_clear) begin
            clr_age <= 19'h0_0000;
            long_run <= watchdog_rate_select_i;
        end else begin
            clr_age <= (clr_age == 19'h7_FFFF) ? clr_age : clr_age + 19'h0_0001;
            long_run <= long_run && watchdog_rate_select_i;
        end
    end

    // Counting: the prescaler steps by one each running cycle and the
    // counter steps only on the tap that the rate input selects
    presc_step_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        run && !svc_wr && !stop_go && !vector_fetch_i && !por_hit && !internal_reset_i && !ovf
        |=> presc == $past(presc) + 12'h001)
        else $error("Prescaler did not advance");

    count_step_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        run && tick && !ovf && !svc_wr && !internal_reset_i |=> cnt == $past(cnt) + 6'h01)
        else $error("Counter did not advance on a tick");

    count_idle_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !(run && tick) && !svc_wr && !internal_reset_i |=> $stable(cnt))
        else $error("Counter moved without a tick");

    // Timeout length, counted from the last clear of the counter; stages
    // 1 to 4 survive a service write, which is where the 2^4 slack comes from
    short_bound_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ovf |-> clr_age >= 19'(wdrt_pkg::WDRT_SHORT_TIMEOUT))
        else $error("Timeout came too early");

    long_bound_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ovf && long_run |-> clr_age >= 19'(wdrt_pkg::WDRT_LONG_TIMEOUT))
        else $error("Long timeout came too early");

    // Service write: counter and upper prescaler stages clear, low stages stay
    service_clears_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        svc_wr && !internal_reset_i |=> cnt == 6'h00 && presc[11:4] == 8'h00)
        else $error("Service write did not clear");

    service_low_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        svc_wr && !stop_go && !vector_fetch_i && !por_hit && !internal_reset_i && !ovf
        |=> presc[3:0] == $past(presc[3:0]))
        else $error("Service write disturbed the low prescaler stages");

    other_write_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_i && !svc_wr && run && tick && !ovf && !internal_reset_i |=> cnt != 6'h00)
        else $error("Write elsewhere cleared the counter");

    // Timeout pulse on the reset pin and the sticky status flag
    pulse_len_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ovf |=> !reset_pin_n_o [*8])
        else $error("Reset pulse too short");

    pulse_exact_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $rose(reset_pin_n_o) |-> low_len == 7'(wdrt_pkg::WDRT_RST_PULSE))
        else $error("Reset pulse length wrong");

    pulse_cap_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !reset_pin_n_o |-> low_len < 7'(wdrt_pkg::WDRT_RST_PULSE))
        else $error("Reset pulse too long");

    pin_drive_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        reset_pin_oe_o == !reset_pin_n_o)
        else $error("Pin enable and level disagree");

    flag_set_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ovf |=> watchdog_flag_o)
        else $error("Flag not set");

    flag_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        watchdog_flag_o && !flag_clear_i |=> watchdog_flag_o)
        else $error("Flag dropped without a clear");

    pulse_freeze_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        pulsing && !svc_wr && !internal_reset_i |=> $stable(cnt))
        else $error("Counter moved during the pulse");

    // Disables: configuration bit, monitor mode with high voltage on either pin and break state with high voltage on the reset pin all hold
    // the counter; none of them may let a reset through
    disabled_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        watchdog_disable_bit_i |-> !ovf)
        else $error("Overflow while disabled");

    disabled_freeze_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        watchdog_disable_bit_i && !svc_wr && !internal_reset_i |=> $stable(cnt))
        else $error("Counter moved while disabled");

    mon_off_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        mon_off && !svc_wr && !internal_reset_i |=> $stable(cnt))
        else $error("Counting in monitor");

    brk_off_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        brk_off |-> !ovf)
        else $error("Overflow in break");

    brk_freeze_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        brk_off && !svc_wr && !internal_reset_i |=> $stable(cnt))
        else $error("Counter moved in break");

    // Stop: only with the enable bit; clears the prescaler and freezes
    // the prescaler and counter until a bus access, a vector fetch or an internal reset
    stop_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        stop_go |=> presc == 12'h000)
        else $error("Stop did not clear");

    stop_ignored_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        stop_exec_i && !stop_enable_i && !stopped |=> !stopped)
        else $error("Stop taken while not enabled");

    stop_freeze_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        stopped && !svc_wr && !internal_reset_i |=> $stable(cnt))
        else $error("Counter moved while stopped");

    presc_frozen_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        stopped && !svc_wr && !stop_go && !vector_fetch_i && !por_hit && !internal_reset_i
        |=> $stable(presc))
        else $error("Prescaler moved while stopped");

    stop_wake_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        stopped && !stop_go && (wr_i || rd_i || vector_fetch_i || internal_reset_i) |=> !stopped)
        else $error("Stop not left on activity");

    // Other clears: vector fetch, power-on delay and internal reset
    fetch_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        vector_fetch_i |=> presc == 12'h000)
        else $error("Fetch did not clear");

    por_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        por_hit |=> presc == 12'h000)
        else $error("Power-on delay did not clear");

    por_done_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        por_done |=> por_done)
        else $error("Power-on delay restarted");

    por_wait_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !por_done && !por_hit |=> !por_done)
        else $error("Power-on delay ended early");

    int_reset_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        internal_reset_i |=> presc == 12'h000 && cnt == 6'h00)
        else $error("Internal reset did not clear");

    // Read port and interrupt line: reads never see watchdog state
    no_irq_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !irq_o)
        else $error("Interrupt raised");

    read_vec_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        rd_i && addr_i == wdrt_pkg::WDRT_SERVICE_ADDR |=> rdata_o == VECTOR_LO)
        else $error("Bad service read");

    read_other_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        rd_i && addr_i != wdrt_pkg::WDRT_SERVICE_ADDR |=> rdata_o == 8'h00)
        else $error("Read of another address returned data");

    // Main scenarios
    timeout_c: cover property (@(posedge clk_i) disable iff (sys_rst_i) ovf);
    service_c: cover property (@(posedge clk_i) disable iff (sys_rst_i) svc_wr);
    stop_c: cover property (@(posedge clk_i) disable iff (sys_rst_i) stop_go);

    // Clears and the end of a pulse
    fetch_c: cover property (@(posedge clk_i) disable iff (sys_rst_i) vector_fetch_i);
    pulse_end_c: cover property (@(posedge clk_i) disable iff (sys_rst_i) $rose(reset_pin_n_o));
endmodule : wdrt_top
